// [core/mahbg_host.sv]
// Host bus end: starts conversions, waits, reads results in order.
`timescale 1ns/1ns
`default_nettype none
module mahbg_host #(
  parameter int NUM_CONV = mahbg_pkg::MAX_CONV,
  parameter int PHASE_DIV = 2
) (
  input wire logic sys_clk, // System clock.
  input wire logic rst, // Synchronous reset, active high.
  mahbg_if.host bus, // Bus to the glue.
  input wire logic start, // Pulse: run one acquisition.
  output logic busy, // Acquisition running.
  output logic store_valid, // Pulse: store_data valid.
  output logic [15:0] store_addr, // Storage address of result.
  output logic [7:0] store_data // Result byte.
);
  initial begin
    if (NUM_CONV < 1 || NUM_CONV > mahbg_pkg::MAX_CONV || PHASE_DIV < 2)
      $error("host parameters out of range");
  end

  typedef enum {S_IDLE, S_START, S_WAIT, S_READ, S_SETTLE} mahbg_hst_type;
  typedef struct packed {
    mahbg_hst_type st;
    logic [2:0] irq_sync;
    logic [7:0] ph_cnt;
    logic [7:0] tmr;
    logic [2:0] idx;
    logic [15:0] addr;
    logic rw;
    logic va;
    logic ph;
    logic sv;
    logic [15:0] sa;
    logic [7:0] sd;
  } mahbg_host_type;

  mahbg_host_type h_r, h_nxt;
  localparam logic [7:0] HOLD = 8'h10;

  always_comb begin
    h_nxt = h_r;
    h_nxt.irq_sync = {h_r.irq_sync[1:0], bus.conversion_done_flag};
    h_nxt.sv = 1'b0;
    h_nxt.ph_cnt = (h_r.ph_cnt == 8'(PHASE_DIV - 1)) ? 8'h00 :
                   h_r.ph_cnt + 8'h01;
    if (h_r.ph_cnt == 8'h00)
      h_nxt.ph = !h_r.ph;
    case (h_r.st)
      S_IDLE: begin
        h_nxt.va = 1'b0;
        h_nxt.rw = 1'b1;
        if (start) begin
          h_nxt.st = S_START;
          h_nxt.addr = mahbg_pkg::BASE_ADDR;
          h_nxt.rw = 1'b0;
          h_nxt.va = 1'b1;
          h_nxt.tmr = HOLD;
        end
      end
      S_START: begin
        h_nxt.tmr = h_r.tmr - 8'h01;
        if (h_r.tmr == 8'h00) begin
          h_nxt.va = 1'b0;
          h_nxt.rw = 1'b1;
          h_nxt.st = S_WAIT;
        end
      end
      S_WAIT: begin
        // Reads begin only once the merged done flag is seen.
        if (h_r.irq_sync[1] && h_r.irq_sync[2]) begin
          h_nxt.st = S_READ;
          h_nxt.idx = 3'h0;
          h_nxt.addr = mahbg_pkg::BASE_ADDR;
          h_nxt.va = 1'b1;
          h_nxt.tmr = HOLD;
        end
      end
      S_READ: begin
        h_nxt.tmr = h_r.tmr - 8'h01;
        if (h_r.tmr == 8'h00) begin
          h_nxt.sv = 1'b1;
          h_nxt.sa = mahbg_pkg::STORE_ADDR + 16'(h_r.idx);
          h_nxt.sd = bus.rdata;
          h_nxt.va = 1'b0;
          h_nxt.st = S_SETTLE;
        end
      end
      S_SETTLE: begin
        if (h_r.idx == 3'(NUM_CONV - 1)) begin
          h_nxt.st = S_IDLE;
        end else begin
          h_nxt.idx = h_r.idx + 3'h1;
          h_nxt.addr = mahbg_pkg::BASE_ADDR + 16'(h_r.idx + 3'h1);
          h_nxt.va = 1'b1;
          h_nxt.tmr = HOLD;
          h_nxt.st = S_READ;
        end
      end
      default: h_nxt.st = S_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst)
      h_r <= '{st: S_IDLE, rw: 1'b1, default: '0};
    else
      h_r <= h_nxt;
  end

  assign bus.addr = h_r.addr;
  assign bus.rd_wr_n = h_r.rw;
  assign bus.valid_address_flag = h_r.va;
  assign bus.phase_clk = h_r.ph;
  assign bus.wdata = 8'h00;
  assign busy = (h_r.st != S_IDLE);
  assign store_valid = h_r.sv;
  assign store_addr = h_r.sa;
  assign store_data = h_r.sd;
endmodule
`default_nettype wire

// [core/mahbg_pkg.sv]
// Package with shared constants for the converter bus glue.
package mahbg_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int MAX_CONV = 8;
  localparam logic [3:0] BASE_PAGE = 4'h5;
  localparam logic [3:0] ALT_PAGE = 4'h4;
  localparam logic [15:0] BASE_ADDR = 16'h5000;
  localparam logic [15:0] PORT_DATA_ADDR = 16'h8006;
  localparam logic [15:0] PORT_CTRL_ADDR = 16'h8007;
  localparam logic [15:0] STORE_ADDR = 16'h0200;
  localparam int PAGE_HI = 15;
  localparam int PAGE_LO = 12;
  localparam int IDX_W = 3;
  localparam logic [11:0] IDX_MASK_HI = 12'hff8;
  localparam int CONV_CLK_DIV = 4;
  localparam int CONV_CYCLES = 64;
endpackage

// [core/mahbg_if.sv]
// Interface joining the host bus end and the converter glue end.
`timescale 1ns/1ns
`default_nettype none
interface mahbg_if;
  logic [15:0] addr;
  logic rd_wr_n;
  logic valid_address_flag;
  logic phase_clk;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic conversion_done_flag;
  modport host (
    output addr, rd_wr_n, valid_address_flag, phase_clk, wdata,
    input rdata, conversion_done_flag
  );
  modport glue (
    input addr, rd_wr_n, valid_address_flag, phase_clk, wdata,
    output rdata, conversion_done_flag
  );
endinterface
`default_nettype wire

// [core/mahbg_glue.sv]
// Converter glue: decode, strobes, converter array and interrupt merge.
//
// Overview of operation
// - Strobe timing comes from phase clock, direction line.
// - Accept accesses only while address valid, except port mode reads.
// - Page select option covers two whole pages.
// - Base write starts every converter together.
// - Simple decode aliases across base page.
// - Interrupt only after all converters finish.
// - Up to eight converters, consecutive result addresses.
// - First converter's clock drives all others.
// - Host waits interrupt, reads, then idles until next start.
// - Host stores results in converter order.
// - Port adapter variant ties select, read active.
// - Port adapter registers sit at adjacent addresses.
`timescale 1ns/1ns
`default_nettype none
module mahbg_glue #(
  parameter int NUM_CONV = mahbg_pkg::MAX_CONV,
  parameter int CONV_CYCLES = mahbg_pkg::CONV_CYCLES,
  parameter int CLK_DIV = mahbg_pkg::CONV_CLK_DIV
) (
  input wire logic sys_clk, // System clock.
  input wire logic rst, // Synchronous reset, active high.
  mahbg_if.glue bus, // Host bus side.
  input wire logic page_sel_mode, // Use combined two-page select.
  input wire logic narrow_decode, // Decode only base..base+7.
  input wire logic port_mode, // Converters sit behind port adapter.
  input wire logic [8*mahbg_pkg::MAX_CONV-1:0] sample_in, // Analog codes.
  output logic [mahbg_pkg::MAX_CONV-1:0] conv_busy, // Per converter busy.
  output logic conv_clk_en, // Shared conversion clock enable.
  output logic [mahbg_pkg::MAX_CONV-1:0] conv_sel // Converter selects.
);
  initial begin
    if (NUM_CONV < 1 || NUM_CONV > mahbg_pkg::MAX_CONV)
      $error("NUM_CONV out of range");
    if (CONV_CYCLES < 1 || CONV_CYCLES > 65535 || CLK_DIV < 1)
      $error("timing parameters out of range");
  end

  typedef struct packed {
    logic [2:0] va_sync;
    logic [2:0] rw_sync;
    logic [2:0] ph_sync;
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr_done;
    logic [15:0] div_cnt;
    logic [mahbg_pkg::MAX_CONV-1:0] busy;
    logic [mahbg_pkg::MAX_CONV-1:0][15:0] cnt;
    logic [mahbg_pkg::MAX_CONV-1:0][7:0] result;
    logic [7:0] rdata;
    logic done;
  } mahbg_state_type;

  mahbg_state_type st_r, st_nxt;

  function automatic logic page_hit(input logic [15:0] a, input logic two);
    page_hit = (a[mahbg_pkg::PAGE_HI:mahbg_pkg::PAGE_LO] ==
                mahbg_pkg::BASE_PAGE) ||
               (two && a[mahbg_pkg::PAGE_HI:mahbg_pkg::PAGE_LO] ==
                mahbg_pkg::ALT_PAGE);
  endfunction

  logic va_q, rw_q, ph_q, sel_any, wr_stb, rd_stb;
  logic [2:0] idx;
  logic clk_tick;

  always_comb begin
    va_q = (st_r.va_sync[1] == st_r.va_sync[2]) ? st_r.va_sync[2] : 1'b0;
    rw_q = st_r.rw_sync[2];
    ph_q = (st_r.ph_sync[1] == st_r.ph_sync[2]) ? st_r.ph_sync[2] : 1'b0;
    // Narrow decode limits the hit to base..base+7 to avoid aliasing.
    sel_any = va_q && page_hit(st_r.addr, page_sel_mode) &&
              (!narrow_decode ||
               (st_r.addr[11:0] & mahbg_pkg::IDX_MASK_HI) == 12'h000);
    wr_stb = sel_any && !rw_q && ph_q;
    rd_stb = (sel_any && rw_q && ph_q) || port_mode;
    idx = st_r.addr[mahbg_pkg::IDX_W-1:0];
    clk_tick = (st_r.div_cnt == 16'(CLK_DIV - 1));
  end

  always_comb begin
    st_nxt = st_r;
    st_nxt.va_sync = {st_r.va_sync[1:0], bus.valid_address_flag};
    st_nxt.rw_sync = {st_r.rw_sync[1:0], bus.rd_wr_n};
    st_nxt.ph_sync = {st_r.ph_sync[1:0], bus.phase_clk};
    st_nxt.addr = bus.addr;
    st_nxt.wdata = bus.wdata;
    // Single shared divider stands for the first converter's oscillator.
    st_nxt.div_cnt = clk_tick ? 16'h0000 : st_r.div_cnt + 16'h0001;
    st_nxt.wr_done = wr_stb;
    for (int i = 0; i < mahbg_pkg::MAX_CONV; i++) begin
      if (i < NUM_CONV) begin
        if (wr_stb && !st_r.wr_done) begin
          st_nxt.busy[i] = 1'b1;
          st_nxt.cnt[i] = 16'(CONV_CYCLES);
        end else if (st_r.busy[i] && clk_tick) begin
          if (st_r.cnt[i] == 16'h0001) begin
            st_nxt.busy[i] = 1'b0;
            st_nxt.result[i] = sample_in[8*i +: 8];
          end
          st_nxt.cnt[i] = st_r.cnt[i] - 16'h0001;
        end
      end else begin
        st_nxt.busy[i] = 1'b0;
      end
    end
    if (rd_stb)
      st_nxt.rdata = st_r.result[idx];
    // Merged flag rises only when no converter remains busy.
    if (wr_stb && !st_r.wr_done)
      st_nxt.done = 1'b0;
    else if (st_r.busy != '0 && st_nxt.busy == '0)
      st_nxt.done = 1'b1;
    else if (rd_stb && !port_mode)
      st_nxt.done = 1'b0;
  end

  always_ff @(posedge sys_clk) begin
    if (rst)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign bus.rdata = st_r.rdata;
  assign bus.conversion_done_flag = st_r.done;
  assign conv_busy = st_r.busy;
  assign conv_clk_en = clk_tick;
  assign conv_sel = (sel_any || port_mode) ?
                    {mahbg_pkg::MAX_CONV{1'b1}} : '0;
endmodule
`default_nettype wire

// [tb/mahbg_asserts.sv]
// Checker for the host bus that joins the two ends.
`timescale 1ns/1ns
`default_nettype none
module mahbg_asserts #(
  parameter int CONV_CYCLES = 4,
  parameter int CLK_DIV = 4
) (
  input wire logic sys_clk, // Clock.
  input wire logic rst, // Reset.
  input wire logic port_mode, // Converters behind port adapter.
  input wire logic [15:0] addr, // Address.
  input wire logic rd_wr_n, // Direction.
  input wire logic valid_address_flag, // Address valid.
  input wire logic phase_clk, // Phase clock.
  input wire logic [7:0] wdata, // Write data.
  input wire logic [7:0] rdata, // Read data.
  input wire logic conversion_done_flag // Merged done.
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic wr;
  logic rd;
  logic [15:0] since_r;
  assign wr = valid_address_flag && !rd_wr_n;
  assign rd = valid_address_flag && rd_wr_n;
  // Cycles since the last write access, saturating.
  always_ff @(posedge sys_clk) begin
    if (rst || wr) begin
      since_r <= 16'h0;
    end else if (since_r != 16'hffff) begin
      since_r <= since_r + 16'h1;
    end
  end
  reset_clear_a: assert property (disable iff (1'b0)
    rst |=> !conversion_done_flag) else $error("done set after reset");
  done_wait_a: assert property ($rose(conversion_done_flag)
    |-> since_r >= 16'((CONV_CYCLES - 1) * CLK_DIV))
    else $error("done raised too early");
  wr_base_a: assert property (wr |-> addr == mahbg_pkg::BASE_ADDR)
    else $error("write off base");
  rd_range_a: assert property (rd
    |-> addr[15:3] == mahbg_pkg::BASE_ADDR[15:3]) else $error("bad read");
  wr_clear_a: assert property (wr && phase_clk
    |-> ##[1:8] !conversion_done_flag) else $error("done kept on write");
  rd_clear_a: assert property (rd && phase_clk && !port_mode
    |-> ##[1:8] !conversion_done_flag) else $error("done kept on read");
  addr_hold_a: assert property (phase_clk && $past(phase_clk)
    && valid_address_flag && $past(valid_address_flag)
    |-> $stable(addr) && $stable(rd_wr_n))
    else $error("address moved in phase");
  rdata_idle_a: assert property ((!valid_address_flag && !port_mode) [*6]
    |=> $stable(rdata)) else $error("read data moved while idle");
  cover property (wr);
  cover property (rd);
  cover property ($rose(conversion_done_flag));
endmodule
`default_nettype wire

// [tb/tb_multi_adc_host_bus_glue.sv]
// Testbench running acquisitions through both ends of the glue.
`timescale 1ns/1ns
`default_nettype none
module tb_multi_adc_host_bus_glue;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic start = 1'b0;
  logic page_sel_mode = 1'b0;
  logic narrow_decode = 1'b0;
  logic port_mode = 1'b0;
  logic [63:0] sample_in = 64'h0;
  logic busy, store_valid, conv_clk_en, all_busy;
  logic [15:0] store_addr;
  logic [7:0] store_data, conv_busy, conv_sel;
  logic [31:0] lfsr = 32'hcbc3;
  logic [23:0] exp_q[$];
  logic [23:0] e;
  int n_errors = 0;
  int compares = 0;
  int cyc = 0;
  int w;
  mahbg_if mahbg_if_i ();
  mahbg_glue #(.CONV_CYCLES(4), .CLK_DIV(4)) mahbg_glue_i (
    .sys_clk(sys_clk), .rst(rst), .bus(mahbg_if_i.glue),
    .page_sel_mode(page_sel_mode), .narrow_decode(narrow_decode),
    .port_mode(port_mode), .sample_in(sample_in), .conv_busy(conv_busy),
    .conv_clk_en(conv_clk_en), .conv_sel(conv_sel));
  mahbg_host mahbg_host_i (.sys_clk(sys_clk), .rst(rst),
    .bus(mahbg_if_i.host), .start(start), .busy(busy),
    .store_valid(store_valid), .store_addr(store_addr),
    .store_data(store_data));
  mahbg_asserts #(.CONV_CYCLES(4), .CLK_DIV(4)) mahbg_asserts_i (
    .sys_clk(sys_clk), .rst(rst), .port_mode(port_mode),
    .addr(mahbg_if_i.addr),
    .rd_wr_n(mahbg_if_i.rd_wr_n),
    .valid_address_flag(mahbg_if_i.valid_address_flag),
    .phase_clk(mahbg_if_i.phase_clk), .wdata(mahbg_if_i.wdata),
    .rdata(mahbg_if_i.rdata),
    .conversion_done_flag(mahbg_if_i.conversion_done_flag));
  function automatic logic [31:0] lfsr_next(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic chk_data(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_addr(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("errors=%0d compares=%0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (conv_busy === 8'hff) all_busy = 1'b1;
    if (cyc == 20000) begin
      n_errors++;
      stop_test();
    end
    if (store_valid === 1'b1) begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 24'hffffff;
      chk_addr(store_addr, e[23:8]);
      chk_data(store_data, e[7:0]);
    end
  end
  initial begin
    repeat (10) @(posedge sys_clk);
    #1 rst = 1'b0;
    for (int t = 0; t < 6; t++) begin
      @(posedge sys_clk);
      #1 lfsr = lfsr_next(lfsr);
      sample_in[31:0] = lfsr;
      lfsr = lfsr_next(lfsr);
      sample_in[63:32] = lfsr;
      page_sel_mode = t[0];
      narrow_decode = t[1];
      port_mode = (t == 5);
      for (int i = 0; i < 8; i++) begin
        exp_q.push_back({mahbg_pkg::STORE_ADDR + 16'(i), sample_in[8*i+:8]});
      end
      all_busy = 1'b0;
      @(posedge sys_clk);
      #1 start = 1'b1;
      @(posedge sys_clk);
      #1 start = 1'b0;
      w = 0;
      while (busy !== 1'b0 && w < 5000) begin
        @(posedge sys_clk);
        w++;
      end
      repeat (3) @(posedge sys_clk);
      chk_data({7'h0, all_busy}, 8'h01);
      chk_data(8'(exp_q.size()), 8'h00);
      $display("test %0d done", t);
    end
    stop_test();
  end
endmodule
`default_nettype wire
